// File: rtl/hbi_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_host_port (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Address/data bus
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] ad_oe_n,
  // Bus strobes and selects
  input  wire logic        addr_latch_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        rw_dir,
  input  wire logic        chip_sel_n,
  input  wire logic        chan_sel,
  input  wire logic        data_ctrl_sel,
  input  wire logic        status_irq_ack_n,
  input  wire logic        pulsed_irq_ack_n,
  output logic             handshake_n,
  // Interrupt pins
  input  wire logic        chain_enable_in0,
  input  wire logic        chain_enable_in1,
  output logic             chain_enable_out0,
  output logic             chain_enable_out1,
  output logic             irq_req_n_chan0,
  output logic             irq_req_n_chan1,
  // Register side
  output logic             reg_wr_pulse,
  output logic             reg_rd_pulse,
  output logic             reg_chan,
  output logic             reg_is_data,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  // Channel interrupt side
  input  wire logic        irq_pending0,
  input  wire logic        irq_pending1,
  input  wire logic        irq_in_service0,
  input  wire logic        irq_in_service1,
  input  wire logic [7:0]  vector0,
  input  wire logic [7:0]  vector1,
  output logic             irq_ack0,
  output logic             irq_ack1,
  // Configuration status
  output logic             cfg_done,
  output logic             cfg_wide,
  output logic             cfg_muxed,
  output logic             cfg_sep_addr,
  output logic             cfg_wait_mode,
  output logic             cfg_dbl_pulse,
  output logic             cfg_no_vector
);
  hbi_pkg::hbi_state_type state, next_state;
  logic        as_q, ds_q, rd_q, wr_q, pa_q;
  logic        as_seen, lat_cs, ptr_armed, pa_first;
  logic        cyc_read, cyc_ack, cyc_pulsed, cyc_cfg, vec_ok;
  logic [7:0]  lat_addr, ptr, vec_data;
  logic [15:0] wbuf, rbuf;
  logic        next_as_seen, next_lat_cs, next_ptr_armed, next_pa_first;
  logic        next_cyc_read, next_cyc_ack, next_cyc_pulsed, next_cyc_cfg, next_vec_ok;
  logic [7:0]  next_lat_addr, next_ptr, next_vec_data, next_reg_addr;
  logic [15:0] next_wbuf, next_rbuf, next_reg_wdata, next_ad_out, next_ad_oe_n;
  logic        next_reg_wr_pulse, next_reg_rd_pulse, next_reg_chan, next_reg_is_data;
  logic        next_irq_ack0, next_irq_ack1, next_handshake_n;
  logic        next_cfg_done, next_cfg_wide, next_cfg_muxed, next_cfg_sep;
  logic        next_cfg_wait, next_cfg_dbl, next_cfg_novec;
  logic        as_rise, ds_fall, rd_fall, wr_fall, pa_fall;
  logic        strobe_low, start_rd, start_wr, cs_ok, ack_cycle, vec_take;
  logic        sel0, sel1, ptr_mode, strobe_held;

  always_comb begin
    as_rise    = ~as_q & addr_latch_strobe_n;
    ds_fall    = ds_q & ~data_strobe_n;
    rd_fall    = rd_q & ~read_strobe_n;
    wr_fall    = wr_q & ~write_strobe_n;
    pa_fall    = pa_q & ~pulsed_irq_ack_n;
    strobe_low = ~data_strobe_n | ~read_strobe_n | ~write_strobe_n;
    start_rd   = (ds_fall & rw_dir) | rd_fall;                      // [R7] [R8]
    start_wr   = (ds_fall & ~rw_dir) | wr_fall;                     // [R7] [R8]
    cs_ok      = cfg_muxed ? lat_cs : ~chip_sel_n;                  // [R9] [R10]
    ack_cycle  = ~status_irq_ack_n | ~pulsed_irq_ack_n;
    // Second pulse of a double acknowledge carries the vector
    vec_take   = (start_rd & ~status_irq_ack_n)                     // [R14]
               | (pa_fall & (~cfg_dbl_pulse | pa_first));           // [R15] [R16]
    sel0       = irq_pending0 & chain_enable_in0;
    sel1       = irq_pending1 & chain_enable_in1 & ~sel0;
    ptr_mode   = ~cfg_muxed & ~cfg_sep_addr;
    strobe_held = cyc_pulsed ? ~pulsed_irq_ack_n : strobe_low;
  end

  always_comb begin
    next_state        = state;
    next_as_seen      = as_seen;
    next_lat_cs       = lat_cs;
    next_lat_addr     = lat_addr;
    next_ptr          = ptr;
    next_ptr_armed    = ptr_armed;
    next_pa_first     = pa_first;
    next_cyc_read     = cyc_read;
    next_cyc_ack      = cyc_ack;
    next_cyc_pulsed   = cyc_pulsed;
    next_cyc_cfg      = cyc_cfg;
    next_vec_ok       = vec_ok;
    next_vec_data     = vec_data;
    next_wbuf         = wbuf;
    next_rbuf         = rbuf;
    next_reg_addr     = reg_addr;
    next_reg_chan     = reg_chan;
    next_reg_is_data  = reg_is_data;
    next_reg_wdata    = reg_wdata;
    next_reg_wr_pulse = 1'b0;
    next_reg_rd_pulse = 1'b0;
    next_irq_ack0     = 1'b0;
    next_irq_ack1     = 1'b0;
    next_cfg_done     = cfg_done;
    next_cfg_wide     = cfg_wide;
    next_cfg_muxed    = cfg_muxed;
    next_cfg_sep      = cfg_sep_addr;
    next_cfg_wait     = cfg_wait_mode;
    next_cfg_dbl      = cfg_dbl_pulse;
    next_cfg_novec    = cfg_no_vector;
    if (!cfg_done && !addr_latch_strobe_n) begin
      next_as_seen = 1'b1;                                          // [R4]
    end
    if (as_rise) begin
      next_lat_cs   = ~chip_sel_n;                                  // [R10]
      next_lat_addr = cfg_sep_addr ? ad_in[15:8] : ad_in[7:0];      // [R6] [R19] [R20]
    end
    if (pa_fall && cfg_dbl_pulse) begin
      next_pa_first = ~pa_first;                                    // [R16]
    end
    case (state)
      hbi_pkg::HBI_IDLE: begin
        if (cfg_done && vec_take) begin
          next_cyc_ack    = 1'b1;
          next_cyc_read   = 1'b1;
          next_cyc_cfg    = 1'b0;
          next_cyc_pulsed = ~pulsed_irq_ack_n & status_irq_ack_n;
          next_irq_ack0   = sel0;
          next_irq_ack1   = sel1;
          next_vec_data   = sel0 ? vector0 : vector1;
          // No-vector option only silences the pulsed path in double-pulse mode
          next_vec_ok     = (sel0 | sel1)
                          & ~(next_cyc_pulsed & cfg_dbl_pulse & cfg_no_vector); // [R16]
          next_state      = hbi_pkg::HBI_SETUP;
        end else if (!cfg_done) begin
          // Reads are ignored until the bus is configured
          if (start_wr && !chip_sel_n) begin                        // [R5] [R24]
            next_cyc_cfg    = 1'b1;
            next_cyc_read   = 1'b0;
            next_cyc_ack    = 1'b0;
            next_cyc_pulsed = 1'b0;
            next_reg_chan   = chan_sel;
            next_state      = hbi_pkg::HBI_SETUP;
          end
        end else if ((start_rd || start_wr) && cs_ok
                     && status_irq_ack_n && pulsed_irq_ack_n) begin // [R9]
          next_cyc_cfg     = 1'b0;
          next_cyc_ack     = 1'b0;
          next_cyc_pulsed  = 1'b0;
          next_cyc_read    = start_rd;
          next_reg_chan    = chan_sel;                              // [R11]
          next_reg_is_data = data_ctrl_sel;                         // [R13]
          if (data_ctrl_sel) begin
            next_reg_addr = hbi_pkg::ADDR_RESET;                    // [R13]
          end else if (cfg_muxed) begin
            next_reg_addr = lat_addr;                               // [R6]
          end else if (cfg_sep_addr) begin
            next_reg_addr = ad_in[15:8];                            // [R20]
          end else begin
            next_reg_addr = ptr;                                    // [R18]
          end
          next_reg_rd_pulse = start_rd;
          next_state        = hbi_pkg::HBI_SETUP;
        end
      end
      hbi_pkg::HBI_SETUP: begin
        next_rbuf  = cyc_ack ? {8'h00, vec_data} : reg_rdata;
        next_state = hbi_pkg::HBI_ACTIVE;
      end
      hbi_pkg::HBI_ACTIVE: begin
        if (strobe_held) begin
          next_wbuf = ad_in;
        end else begin
          next_state = hbi_pkg::HBI_IDLE;
          if (cyc_cfg) begin
            next_cfg_done  = 1'b1;
            next_cfg_wide  = wbuf[hbi_pkg::BCR_WIDE];               // [R1]
            next_cfg_sep   = ~wbuf[hbi_pkg::BCR_WIDE]
                           & wbuf[hbi_pkg::SEP_ADDR_FLAG]
                           & (wbuf[14:8] == hbi_pkg::SEP_ADDR_ZERO); // [R2] [R3]
            next_cfg_muxed = as_seen;                               // [R4]
            next_cfg_wait  = reg_chan;                              // [R12]
            next_cfg_dbl   = wbuf[hbi_pkg::BCR_DBL_PULSE];          // [R15]
            next_cfg_novec = wbuf[hbi_pkg::BCR_NO_VECTOR];
          end else if (!cyc_read) begin
            if (ptr_mode && !reg_is_data && !ptr_armed) begin
              next_ptr       = wbuf[7:0];                           // [R18]
              next_ptr_armed = 1'b1;
            end else begin
              next_reg_wr_pulse = 1'b1;
              next_reg_wdata    = cfg_wide ? wbuf : {8'h00, wbuf[7:0]}; // [R19] [R20]
              if (ptr_mode && !reg_is_data) begin
                next_ptr_armed = 1'b0;
              end
            end
          end
        end
      end
      default: next_state = hbi_pkg::HBI_IDLE;
    endcase
    next_ad_out      = next_rbuf;
    next_ad_oe_n     = hbi_pkg::OE_ALL_OFF;
    next_handshake_n = 1'b1;
    if (next_state == hbi_pkg::HBI_ACTIVE && next_cyc_read && (!next_cyc_ack || next_vec_ok)) begin
      next_ad_oe_n = (cfg_wide && !next_cyc_ack) ? hbi_pkg::OE_WORD : hbi_pkg::OE_LOW_BYTE;
    end
    // Wait sense holds the host for the setup cycle, ready sense marks data valid
    if (cfg_wait_mode) begin
      next_handshake_n = ~(next_state == hbi_pkg::HBI_SETUP);       // [R12] [R17]
    end else if (next_state == hbi_pkg::HBI_ACTIVE && (!next_cyc_ack || next_vec_ok)) begin
      next_handshake_n = 1'b0;                                      // [R17]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hbi_pkg::HBI_IDLE;
      {as_q, ds_q, rd_q, wr_q, pa_q} <= 5'h1F;
      {as_seen, lat_cs, ptr_armed, pa_first} <= 4'h0;
      {cyc_read, cyc_ack, cyc_pulsed, cyc_cfg, vec_ok} <= 5'h00;
      lat_addr <= hbi_pkg::ADDR_RESET;
      ptr <= hbi_pkg::ADDR_RESET;
      vec_data <= hbi_pkg::ADDR_RESET;
      wbuf <= hbi_pkg::DATA_RESET;
      rbuf <= hbi_pkg::DATA_RESET;
      reg_addr <= hbi_pkg::ADDR_RESET;
      reg_wdata <= hbi_pkg::DATA_RESET;
      ad_out <= hbi_pkg::DATA_RESET;
      ad_oe_n <= hbi_pkg::OE_ALL_OFF;
      {reg_wr_pulse, reg_rd_pulse, reg_chan, reg_is_data} <= 4'h0;
      {irq_ack0, irq_ack1} <= 2'h0;
      handshake_n <= 1'b1;
      {cfg_done, cfg_wide, cfg_muxed, cfg_sep_addr} <= 4'h0;
      {cfg_wait_mode, cfg_dbl_pulse, cfg_no_vector} <= 3'h0;
    end else begin
      state <= next_state;
      as_q <= addr_latch_strobe_n;
      ds_q <= data_strobe_n;
      rd_q <= read_strobe_n;
      wr_q <= write_strobe_n;
      pa_q <= pulsed_irq_ack_n;
      as_seen <= next_as_seen;
      lat_cs <= next_lat_cs;
      ptr_armed <= next_ptr_armed;
      pa_first <= next_pa_first;
      cyc_read <= next_cyc_read;
      cyc_ack <= next_cyc_ack;
      cyc_pulsed <= next_cyc_pulsed;
      cyc_cfg <= next_cyc_cfg;
      vec_ok <= next_vec_ok;
      lat_addr <= next_lat_addr;
      ptr <= next_ptr;
      vec_data <= next_vec_data;
      wbuf <= next_wbuf;
      rbuf <= next_rbuf;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      ad_out <= next_ad_out;
      ad_oe_n <= next_ad_oe_n;
      reg_wr_pulse <= next_reg_wr_pulse;
      reg_rd_pulse <= next_reg_rd_pulse;
      reg_chan <= next_reg_chan;
      reg_is_data <= next_reg_is_data;
      irq_ack0 <= next_irq_ack0;
      irq_ack1 <= next_irq_ack1;
      handshake_n <= next_handshake_n;
      cfg_done <= next_cfg_done;
      cfg_wide <= next_cfg_wide;
      cfg_muxed <= next_cfg_muxed;
      cfg_sep_addr <= next_cfg_sep;
      cfg_wait_mode <= next_cfg_wait;
      cfg_dbl_pulse <= next_cfg_dbl;
      cfg_no_vector <= next_cfg_novec;
    end
  end

  hbi_irq_chain u_chain0 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pending    (irq_pending0),
    .in_service (irq_in_service0),
    .ack_cycle  (ack_cycle),
    .chain_in   (chain_enable_in0),
    .chain_out  (chain_enable_out0),
    .irq_req_n  (irq_req_n_chan0)
  );

  hbi_irq_chain u_chain1 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pending    (irq_pending1),
    .in_service (irq_in_service1),
    .ack_cycle  (ack_cycle),
    .chain_in   (chain_enable_in1),
    .chain_out  (chain_enable_out1),
    .irq_req_n  (irq_req_n_chan1)
  );

  property p_cfg_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      cfg_done |=> cfg_done;
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky) // [R5]
    else $error("configuration lost after being written");

  property p_cfg_wide;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(cfg_done) |-> cfg_wide == $past(wbuf[2]);
  endproperty
  a_cfg_wide: assert property (p_cfg_wide) // [R1]
    else $error("bus width does not follow configuration bit 2");

  property p_no_access_unconfigured;
    @(posedge sys_clk) disable iff (!rst_n)
      !cfg_done |-> !reg_wr_pulse && !reg_rd_pulse;
  endproperty
  a_no_access_unconfigured: assert property (p_no_access_unconfigured) // [R24]
    else $error("register access before configuration");

  property p_data_direct;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd_pulse |-> reg_is_data == $past(data_ctrl_sel) && reg_chan == $past(chan_sel);
  endproperty
  a_data_direct: assert property (p_data_direct) // [R13]
    else $error("data select or channel not taken from the strobe cycle");

  property p_ready_data;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd_pulse && !cfg_wait_mode) |-> handshake_n ##1 !handshake_n;
  endproperty
  a_ready_data: assert property (p_ready_data) // [R17]
    else $error("ready not given one cycle after a read starts");

  property p_wait_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_wait_mode && state == hbi_pkg::HBI_SETUP) |-> !handshake_n ##1 handshake_n;
  endproperty
  a_wait_hold: assert property (p_wait_hold) // [R12]
    else $error("wait sense not held for exactly the setup cycle");

  property p_narrow_upper_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !cfg_wide |-> ad_oe_n[15:8] == 8'hFF;
  endproperty
  a_narrow_upper_off: assert property (p_narrow_upper_off) // [R20]
    else $error("upper byte driven on an 8-bit bus");

  property p_double_first;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_dbl_pulse && pa_fall && !pa_first && state == hbi_pkg::HBI_IDLE)
        |=> !irq_ack0 && !irq_ack1 && state == hbi_pkg::HBI_IDLE;
  endproperty
  a_double_first: assert property (p_double_first) // [R16]
    else $error("first pulse of a double acknowledge acted on");
endmodule // hbi_host_port
`default_nettype wire

// File: rtl/hbi_irq_chain.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_irq_chain (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Channel interrupt state
  input  wire logic pending,
  input  wire logic in_service,
  input  wire logic ack_cycle,
  // Daisy chain
  input  wire logic chain_in,
  output logic      chain_out,
  output logic      irq_req_n
);
  logic next_chain_out;
  logic next_irq_req_n;

  always_comb begin
    next_irq_req_n = ~pending;                                     // [R21]
    next_chain_out = chain_in & ~in_service & ~(pending & ack_cycle); // [R22]
  end

  // Push-pull: the request is always driven, never released to float
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_out <= 1'b0;
      irq_req_n <= 1'b1;
    end else begin
      chain_out <= next_chain_out;
      irq_req_n <= next_irq_req_n;
    end
  end

  property p_chain_block;
    @(posedge sys_clk) disable iff (!rst_n)
      (!chain_in || in_service) |=> !chain_out;
  endproperty
  a_chain_block: assert property (p_chain_block) // [R22]
    else $error("chain enable out not low while chain blocked");

  property p_chain_pass;
    @(posedge sys_clk) disable iff (!rst_n)
      (chain_in && !in_service && !pending) |=> chain_out;
  endproperty
  a_chain_pass: assert property (p_chain_pass) // [R22]
    else $error("chain enable out not passed through");

  property p_irq_follow;
    @(posedge sys_clk) disable iff (!rst_n)
      pending |=> !irq_req_n;
  endproperty
  a_irq_follow: assert property (p_irq_follow) // [R21]
    else $error("interrupt request not driven for pending channel");
endmodule // hbi_irq_chain
`default_nettype wire

// File: rtl/hbi_pkg.sv
// What this block does
// R1: Bus configuration bit 2 written as one selects the 16-bit data bus.
// R2: Plain 8-bit bus: bit 2 written zero, upper eight bus lines held low.
// R3: Separate-address 8-bit bus: bit 2 zero, top line high, next seven low.
// R4: Address strobe seen before or during configuration write selects multiplexed bus.
// R5: First write after reset always goes to the bus configuration register.
// R6: Multiplexed modes latch the address on the address strobe; otherwise strobe unused.
// R7: Data strobe moves read or write data per the sampled direction input.
// R8: Read strobe drives data or vector; write strobe captures write data.
// R9: Chip select needed for register access, ignored during acknowledge cycles.
// R10: Multiplexed bus latches chip select at address strobe rising edge.
// R11: Channel select high routes to channel A, low to channel B.
// R12: Channel select during configuration write picks wait or ready handshake sense.
// R13: Data/control select high gives direct data register access, overriding address.
// R14: Status acknowledge low marks an acknowledge cycle that may return a vector.
// R15: Pulsed acknowledge accepted as single or double pulse per configuration.
// R16: Double pulse: first pulse ignored, second returns vector unless no-vector set.
// R17: Handshake output marks read data, write acceptance, or valid vector.
// R18: Nonmultiplexed without separate address uses a pointer loaded first by host.
// R19: 16-bit multiplexed mode latches address from low byte, moves 16-bit data.
// R20: Separate-address 8-bit modes: data on low byte, address on upper byte.
// R21: Each channel drives its own push-pull active-low interrupt request.
// R22: Chain enable out low when chain in low, in service, or pending during acknowledge.
// R23: Host writes zero to every reserved bit of every register.
// R24: Until configured, no width or addressing option applies.
package hbi_pkg;
  localparam int          BUS_W            = 16;
  localparam int          ADDR_W           = 8;
  localparam int          BCR_DBL_PULSE    = 0;
  localparam int          BCR_NO_VECTOR    = 1;
  localparam int          BCR_WIDE         = 2;
  localparam int          SEP_ADDR_FLAG    = 15;
  localparam logic [6:0]  SEP_ADDR_ZERO    = 7'h00;
  localparam logic [7:0]  ADDR_RESET       = 8'h00;
  localparam logic [15:0] DATA_RESET       = 16'h0000;
  localparam logic [15:0] OE_ALL_OFF       = 16'hFFFF;
  localparam logic [15:0] OE_LOW_BYTE      = 16'hFF00;
  localparam logic [15:0] OE_WORD          = 16'h0000;

  typedef enum logic [1:0] {
    HBI_IDLE   = 2'b00,
    HBI_SETUP  = 2'b01,
    HBI_ACTIVE = 2'b10
  } hbi_state_type;
endpackage

// File: tb/hbi_reg_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_reg_model (
  // Clock
  input  wire logic        sys_clk,
  // Register side of the host port
  input  wire logic        reg_wr_pulse,
  input  wire logic        reg_rd_pulse,
  input  wire logic        reg_chan,
  input  wire logic        reg_is_data,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata
);
  logic [15:0] mem [0:255];
  logic [7:0]  last_addr = 8'h00;
  logic [15:0] last_data = 16'h0000;
  logic        last_chan = 1'b0;
  logic        last_dat  = 1'b0;
  int          rd_count  = 0;

  // The port takes read data at the edge that ends the pulse, so answer at once
  assign reg_rdata = reg_rd_pulse ? mem[reg_addr] : 16'h0000;

  always @(posedge sys_clk) begin
    if (reg_wr_pulse) begin
      mem[reg_addr] <= reg_wdata;
      last_addr <= reg_addr;
      last_data <= reg_wdata;
      last_chan <= reg_chan;
      last_dat  <= reg_is_data;
    end
    if (reg_rd_pulse) begin
      rd_count  <= rd_count + 1;
    end
  end
endmodule // hbi_reg_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] ad_in = 16'h0000;
  logic        as_n = 1'b1, ds_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, rw_dir = 1'b0;
  logic        cs_n = 1'b1, chan_sel = 1'b0, dc_sel = 1'b0, sack_n = 1'b1, pack_n = 1'b1;
  logic        cei0 = 1'b1, cei1 = 1'b1, pend0 = 1'b0, pend1 = 1'b0, isv0 = 1'b0, isv1 = 1'b0;
  logic [7:0]  vec0 = 8'h5A, vec1 = 8'hC3;
  wire logic [15:0] ad_out, ad_oe_n, reg_wdata, reg_rdata;
  wire logic [7:0]  reg_addr;
  wire logic        hs_n, ceo0, ceo1, irq0_n, irq1_n, wr_p, rd_p, r_chan, r_dat;
  wire logic        ack0, ack1;
  wire logic        c_done, c_wide, c_mux, c_sep, c_wait, c_dbl, c_nov;
  logic [15:0] d, oe;
  logic [1:0]  chain_seen, ack_seen, hs_seen;
  // Second phase uses the data strobe with direction instead of separate strobes
  logic        use_ds = 1'b0;
  int          bad_count = 0;
  int          comparisons = 0;

  always #20 sys_clk = ~sys_clk;

  hbi_host_port u_hbi_host_port (.sys_clk(sys_clk), .rst_n(rst_n), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_latch_strobe_n(as_n), .data_strobe_n(ds_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .rw_dir(rw_dir), .chip_sel_n(cs_n),
    .chan_sel(chan_sel), .data_ctrl_sel(dc_sel), .status_irq_ack_n(sack_n),
    .pulsed_irq_ack_n(pack_n), .handshake_n(hs_n), .chain_enable_in0(cei0),
    .chain_enable_in1(cei1), .chain_enable_out0(ceo0), .chain_enable_out1(ceo1),
    .irq_req_n_chan0(irq0_n), .irq_req_n_chan1(irq1_n), .reg_wr_pulse(wr_p),
    .reg_rd_pulse(rd_p), .reg_chan(r_chan), .reg_is_data(r_dat), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_pending0(pend0),
    .irq_pending1(pend1), .irq_in_service0(isv0), .irq_in_service1(isv1),
    .vector0(vec0), .vector1(vec1), .irq_ack0(ack0), .irq_ack1(ack1), .cfg_done(c_done),
    .cfg_wide(c_wide), .cfg_muxed(c_mux), .cfg_sep_addr(c_sep), .cfg_wait_mode(c_wait),
    .cfg_dbl_pulse(c_dbl), .cfg_no_vector(c_nov));

  hbi_reg_model u_hbi_reg_model (.sys_clk(sys_clk), .reg_wr_pulse(wr_p),
    .reg_rd_pulse(rd_p), .reg_chan(r_chan), .reg_is_data(r_dat), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Address strobe never moves: this host runs the nonmultiplexed bus
  task automatic bus_wr(input logic [15:0] wd, input logic dc, input logic cs);
    @(negedge sys_clk);
    ad_in = wd;
    dc_sel = dc;
    cs_n = cs;
    rw_dir = 1'b0;
    wr_n = use_ds;
    ds_n = ~use_ds;
    repeat (4) @(negedge sys_clk);
    wr_n = 1'b1;
    ds_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    cs_n = 1'b1;
    ad_in = ~wd;
  endtask

  // Strobe held past the wait-mode handshake so data has settled
  task automatic bus_rd(input logic dc, output logic [15:0] rdv, output logic [15:0] rdoe);
    @(negedge sys_clk);
    dc_sel = dc;
    cs_n = 1'b0;
    rw_dir = 1'b1;
    rd_n = use_ds;
    ds_n = ~use_ds;
    @(negedge sys_clk);
    hs_seen[1] = hs_n;
    repeat (3) @(negedge sys_clk);
    hs_seen[0] = hs_n;
    rdv = ad_out;
    rdoe = ad_oe_n;
    rd_n = 1'b1;
    ds_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    cs_n = 1'b1;
  endtask

  task automatic ack_pulse(output logic [15:0] rdv, output logic [15:0] rdoe);
    @(negedge sys_clk);
    pack_n = 1'b0;
    @(negedge sys_clk);
    ack_seen = {ack0, ack1};
    repeat (3) @(negedge sys_clk);
    rdv = ad_out;
    rdoe = ad_oe_n;
    chain_seen = {ceo0, ceo1};
    pack_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    bus_rd(1'b0, d, oe);
    `CHK("early read", 0, u_hbi_reg_model.rd_count)
    bus_wr(16'h0004, 1'b0, 1'b1);
    `CHK("unselected cfg", 1'b0, c_done)
    chan_sel = 1'b1;
    bus_wr(16'h0005, 1'b0, 1'b0);
    `CHK("cfg_done", 1'b1, c_done)
    `CHK("cfg_wide", 1'b1, c_wide)
    `CHK("cfg_muxed", 1'b0, c_mux)
    `CHK("cfg_sep_addr", 1'b0, c_sep)
    `CHK("cfg_wait_mode", 1'b1, c_wait)
    `CHK("cfg_dbl_pulse", 1'b1, c_dbl)
    `CHK("cfg_no_vector", 1'b0, c_nov)
    bus_wr(16'h0012, 1'b0, 1'b0);
    bus_wr(16'hA5C3, 1'b0, 1'b0);
    `CHK("ptr addr", 8'h12, u_hbi_reg_model.last_addr)
    `CHK("ptr data", 16'hA5C3, u_hbi_reg_model.last_data)
    `CHK("chan A", 1'b1, u_hbi_reg_model.last_chan)
    bus_wr(16'h0012, 1'b0, 1'b0);
    bus_rd(1'b0, d, oe);
    `CHK("read data", 16'hA5C3, d)
    `CHK("read drive", 16'h0000, oe)
    `CHK("wait sense", 2'b01, hs_seen)
    chan_sel = 1'b0;
    bus_wr(16'h3C96, 1'b1, 1'b0);
    `CHK("direct", 1'b1, u_hbi_reg_model.last_dat)
    `CHK("chan B", 1'b0, u_hbi_reg_model.last_chan)
    `CHK("direct data", 16'h3C96, u_hbi_reg_model.last_data)
    pend0 = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("irq0", 1'b0, irq0_n)
    `CHK("chain idle", 1'b1, ceo0)
    ack_pulse(d, oe);
    `CHK("first pulse", 16'hFFFF, oe)
    `CHK("first pulse ack", 2'b00, ack_seen)
    ack_pulse(d, oe);
    `CHK("vector0", vec0, d[7:0])
    `CHK("vector drive", 8'h00, oe[7:0])
    `CHK("chain in ack", 2'b01, chain_seen)
    `CHK("vector ack", 2'b10, ack_seen)
    sack_n = 1'b0;
    bus_rd(1'b0, d, oe);
    `CHK("status vector0", vec0, d[7:0])
    pend0 = 1'b0;
    pend1 = 1'b1;
    repeat (3) @(negedge sys_clk);
    bus_rd(1'b0, d, oe);
    `CHK("status vector1", vec1, d[7:0])
    sack_n = 1'b1;
    cei0 = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("chain blocked", 1'b0, ceo0)
    `CHK("irq0 clear", 1'b1, irq0_n)
    `CHK("irq1", 1'b0, irq1_n)
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK("cfg after reset", 1'b0, c_done)
    use_ds = 1'b1;
    chan_sel = 1'b0;
    bus_wr(16'h8000, 1'b0, 1'b0);
    `CHK("sep cfg", 5'h12, {c_done, c_wide, c_mux, c_sep, c_wait})
    bus_wr(16'h2177, 1'b0, 1'b0);
    `CHK("sep addr", 8'h21, u_hbi_reg_model.last_addr)
    `CHK("sep data", 16'h0077, u_hbi_reg_model.last_data)
    @(negedge sys_clk);
    ad_in = 16'h2100;
    bus_rd(1'b0, d, oe);
    `CHK("ds read", 16'h0077, d)
    `CHK("ds read drive", 16'hFF00, oe)
    `CHK("ready sense", 2'b10, hs_seen)
    ack_pulse(d, oe);
    `CHK("single vector1", vec1, d[7:0])
    `CHK("single ack", 2'b01, ack_seen)
    `CHK("chain in ack B", 2'b00, chain_seen)
    pend1 = 1'b0;
    isv1 = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("chain in service", 1'b0, ceo1)
    results();
  end
endmodule // tb_top
`default_nettype wire
